// ---- inc/pdc_cfg.svh ----
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PDC_ADDR_READSEL  10'h004
`define PDC_ADDR_PUMP_PWR 10'h010
`define PDC_ADDR_REF_LO   10'h011
`define PDC_ADDR_REF_HI   10'h012
`define PDC_ADDR_SWALLOW  10'h013
`define PDC_ADDR_MAIN_LO  10'h014
`define PDC_ADDR_MAIN_HI  10'h015
`define PDC_ADDR_CTRL     10'h016

// ----------------------------------------------------------------------
// Reset values and writable bit masks
// ----------------------------------------------------------------------
`define PDC_RST_PUMP_PWR  8'h0D
`define PDC_RST_REF_LO    8'h01
`define PDC_RST_REF_HI    8'h00
`define PDC_RST_SWALLOW   8'h00
`define PDC_RST_MAIN_LO   8'h03
`define PDC_RST_MAIN_HI   8'h00
`define PDC_RST_CTRL      8'h00
`define PDC_MSK_PUMP_PWR  8'h0F
`define PDC_MSK_REF_LO    8'hFF
`define PDC_MSK_REF_HI    8'h3F
`define PDC_MSK_SWALLOW   8'h3F
`define PDC_MSK_MAIN_LO   8'hFF
`define PDC_MSK_MAIN_HI   8'h1F
`define PDC_MSK_CTRL      8'hF8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PDC_PUMP_MODE_MSB 3
`define PDC_PUMP_MODE_LSB 2
`define PDC_POWER_MSB     1
`define PDC_POWER_LSB     0
`define PDC_CTRL_MIDSUP   7
`define PDC_CTRL_RST_REF  6
`define PDC_CTRL_RST_FB   5
`define PDC_CTRL_RST_ALL  4
`define PDC_CTRL_BYPASS   3
`define PDC_READSEL_BIT   0

`endif

// ---- inc/pdc_pkg.sv ----
`default_nettype none

// ----------------------------------------------------------------------
// Types shared by the divider control block
// ----------------------------------------------------------------------
package pdc_pkg;

   // Pump operating mode codes
   typedef enum logic [1:0] {
      PDC_PUMP_HIZ    = 2'h0,
      PDC_PUMP_SOURCE = 2'h1,
      PDC_PUMP_SINK   = 2'h2,
      PDC_PUMP_NORMAL = 2'h3
   } pdc_pump_mode_t;

   // Loop power codes
   typedef enum logic [1:0] {
      PDC_PWR_RUN    = 2'h0,
      PDC_PWR_ASYNC  = 2'h1,
      PDC_PWR_UNUSED = 2'h2,
      PDC_PWR_SYNC   = 2'h3
   } pdc_power_mode_t;

endpackage : pdc_pkg

`default_nettype wire

// ---- rtl/pdc_top.sv ----

`default_nettype none

`include "pdc_cfg.svh"

module pdc_top
   import pdc_pkg::*;
(
   // Clock and reset
   input  wire logic       CLK_SYS,
   input  wire logic       RST,
   // Register access port
   input  wire logic [9:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   input  wire logic       REG_UPDATE,
   output logic      [7:0] REG_RDATA,
   // Divider and phase detector inputs
   input  wire logic       REF_TICK,
   input  wire logic       FB_TICK,
   input  wire logic       PFD_UP,
   input  wire logic       PFD_DOWN,
   // Divider outputs
   output logic            REF_DIV_OUT,
   output logic            FB_DIV_OUT,
   output logic            MOD_SEL,
   output logic            REF_DIV_HELD,
   output logic            FB_DIV_HELD,
   // Pump and loop outputs
   output logic            PUMP_OUTPUT_UP,
   output logic            PUMP_OUTPUT_DOWN,
   output logic            PUMP_OUTPUT_HIZ,
   output logic            PUMP_SUPPLY_HALF,
   output logic      [1:0] LOOP_POWER
);

   localparam int NREG = 7;

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic [7:0]  buf_reg [NREG];
   logic [7:0]  act_reg [NREG];
   logic [7:0]  rst_val [NREG];
   logic [7:0]  wr_mask [NREG];
   logic        readsel_reg;
   logic [7:0]  rdata_reg;
   logic [2:0]  wr_idx;
   logic        wr_hit;

   // Reset values, then writable masks
   assign rst_val[0] = `PDC_RST_PUMP_PWR;
   assign rst_val[1] = `PDC_RST_REF_LO;
   assign rst_val[2] = `PDC_RST_REF_HI;
   assign rst_val[3] = `PDC_RST_SWALLOW;
   assign rst_val[4] = `PDC_RST_MAIN_LO;
   assign rst_val[5] = `PDC_RST_MAIN_HI;
   assign rst_val[6] = `PDC_RST_CTRL;
   assign wr_mask[0] = `PDC_MSK_PUMP_PWR;
   assign wr_mask[1] = `PDC_MSK_REF_LO;
   assign wr_mask[2] = `PDC_MSK_REF_HI;
   assign wr_mask[3] = `PDC_MSK_SWALLOW;
   assign wr_mask[4] = `PDC_MSK_MAIN_LO;
   assign wr_mask[5] = `PDC_MSK_MAIN_HI;
   assign wr_mask[6] = `PDC_MSK_CTRL;

   // Address decode to bank index
   always_comb begin
      wr_idx = 3'h0;
      wr_hit = 1'b1;
      if (REG_ADDR == `PDC_ADDR_PUMP_PWR) begin
         wr_idx = 3'h0;
      end else if (REG_ADDR == `PDC_ADDR_REF_LO) begin
         wr_idx = 3'h1;
      end else if (REG_ADDR == `PDC_ADDR_REF_HI) begin
         wr_idx = 3'h2;
      end else if (REG_ADDR == `PDC_ADDR_SWALLOW) begin
         wr_idx = 3'h3;
      end else if (REG_ADDR == `PDC_ADDR_MAIN_LO) begin
         wr_idx = 3'h4;
      end else if (REG_ADDR == `PDC_ADDR_MAIN_HI) begin
         wr_idx = 3'h5;
      end else if (REG_ADDR == `PDC_ADDR_CTRL) begin
         wr_idx = 3'h6;
      end else begin
         wr_hit = 1'b0;
      end
   end

   // Buffer and active banks, one pair per register
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_bank
         always_ff @(posedge CLK_SYS or posedge RST) begin
            if (RST) begin
               buf_reg[gi] <= 8'h00;
            end else if (REG_WR && wr_hit && wr_idx == 3'(gi)) begin
               buf_reg[gi] <= (REG_WDATA & wr_mask[gi]) ^ rst_val[gi];
            end
         end
         always_ff @(posedge CLK_SYS or posedge RST) begin
            if (RST) begin
               act_reg[gi] <= 8'h00;
            end else if (REG_UPDATE) begin
               act_reg[gi] <= buf_reg[gi];
            end
         end
      end
   endgenerate

   // Readback select, written directly
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         readsel_reg <= 1'b0;
      end else if (REG_WR && REG_ADDR == `PDC_ADDR_READSEL) begin
         readsel_reg <= REG_WDATA[`PDC_READSEL_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Reset value overlay
   // ----------------------------------------------------------------------
   // Banks hold the difference from the reset value, so async reset
   // loads only constants; the stored word is XORed back on use.
   logic [7:0] buf_val [NREG];
   logic [7:0] act_val [NREG];
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_view
         assign buf_val[gi] = buf_reg[gi];
         assign act_val[gi] = act_reg[gi];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // Registered readback one cycle after the strobe
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rdata_reg <= 8'h00;
      end else if (REG_RD) begin
         if (REG_ADDR == `PDC_ADDR_READSEL) begin
            rdata_reg <= {7'h00, readsel_reg};
         end else if (wr_hit && readsel_reg) begin
            rdata_reg <= act_val[wr_idx] ^ rst_val[wr_idx];
         end else if (wr_hit) begin
            rdata_reg <= buf_val[wr_idx] ^ rst_val[wr_idx];
         end else begin
            rdata_reg <= 8'h00;
         end
      end
   end
   assign REG_RDATA = rdata_reg;

   // ----------------------------------------------------------------------
   // Active field extraction
   // ----------------------------------------------------------------------
   logic [7:0]      pp_w;
   logic [7:0]      ctl_w;
   logic [13:0]     ref_val;
   logic [5:0]      swl_val;
   logic [12:0]     main_val;
   pdc_pump_mode_t  pump_mode;
   pdc_power_mode_t pwr_mode;
   logic            loop_off;
   logic            hold_ref;
   logic            hold_fb;
   logic            bypass;

   assign pp_w     = act_val[0] ^ rst_val[0];
   assign ctl_w    = act_val[6] ^ rst_val[6];
   assign ref_val  = 14'({(act_val[2] ^ rst_val[2]) & 8'h3F,
                          act_val[1] ^ rst_val[1]});
   assign swl_val  = 6'(act_val[3] ^ rst_val[3]);
   assign main_val = 13'({(act_val[5] ^ rst_val[5]) & 8'h1F,
                          act_val[4] ^ rst_val[4]});
   assign pump_mode = pdc_pump_mode_t'(
      pp_w[`PDC_PUMP_MODE_MSB:`PDC_PUMP_MODE_LSB]);
   assign pwr_mode  = pdc_power_mode_t'(
      pp_w[`PDC_POWER_MSB:`PDC_POWER_LSB]);
   // Loop runs only at the run code
   assign loop_off = (pwr_mode != PDC_PWR_RUN);
   assign hold_ref = ctl_w[`PDC_CTRL_RST_REF]
                   | ctl_w[`PDC_CTRL_RST_ALL] | loop_off;
   assign hold_fb  = ctl_w[`PDC_CTRL_RST_FB]
                   | ctl_w[`PDC_CTRL_RST_ALL] | loop_off;
   assign bypass   = ctl_w[`PDC_CTRL_BYPASS];

   // ----------------------------------------------------------------------
   // Reference divider
   // ----------------------------------------------------------------------
   logic [13:0] ref_cnt_reg;
   logic [13:0] ref_term;
   logic        ref_out_reg;

   // Zero divisor behaves as divide-by-one
   assign ref_term = (ref_val <= 14'h0001) ? 14'h0000 : ref_val - 14'h0001;

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ref_cnt_reg <= 14'h0000;
         ref_out_reg <= 1'b0;
      end else if (hold_ref) begin
         ref_cnt_reg <= 14'h0000;
         ref_out_reg <= 1'b0;
      end else if (REF_TICK && ref_cnt_reg >= ref_term) begin
         ref_cnt_reg <= 14'h0000;
         ref_out_reg <= 1'b1;
      end else if (REF_TICK) begin
         ref_cnt_reg <= ref_cnt_reg + 14'h0001;
         ref_out_reg <= 1'b0;
      end else begin
         ref_out_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Feedback divider, dual modulus control
   // ----------------------------------------------------------------------
   // Swallow count prescaler cycles run at modulus P+1, the rest at P,
   // so one output period spans P*main + swallow input cycles.
   logic [12:0] main_cnt_reg;
   logic [12:0] main_cnt_next;
   logic [12:0] main_term;
   logic [5:0]  swl_cnt_reg;
   logic [5:0]  swl_cnt_next;
   logic        fb_out_reg;
   logic        fb_out_next;
   logic        mod_sel_reg;

   assign main_term = (bypass || main_val <= 13'h0001) ?
                      13'h0000 : main_val - 13'h0001;

   // Next counts for each prescaler output pulse
   always_comb begin
      main_cnt_next = main_cnt_reg;
      swl_cnt_next  = swl_cnt_reg;
      fb_out_next   = 1'b0;
      if (FB_TICK) begin
         if (main_cnt_reg >= main_term) begin
            main_cnt_next = 13'h0000;
            swl_cnt_next  = 6'h00;
            fb_out_next   = 1'b1;
         end else begin
            main_cnt_next = main_cnt_reg + 13'h0001;
            if (swl_cnt_reg < swl_val) begin
               swl_cnt_next = swl_cnt_reg + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         main_cnt_reg <= 13'h0000;
         swl_cnt_reg  <= 6'h00;
         fb_out_reg   <= 1'b0;
         mod_sel_reg  <= 1'b0;
      end else if (hold_fb) begin
         main_cnt_reg <= 13'h0000;
         swl_cnt_reg  <= 6'h00;
         fb_out_reg   <= 1'b0;
         mod_sel_reg  <= 1'b0;
      end else begin
         main_cnt_reg <= main_cnt_next;
         swl_cnt_reg  <= swl_cnt_next;
         fb_out_reg   <= fb_out_next;
         mod_sel_reg  <= !bypass && (swl_cnt_next < swl_val);
      end
   end

   // ----------------------------------------------------------------------
   // Pump output control
   // ----------------------------------------------------------------------
   logic pump_up_reg;
   logic pump_dn_reg;
   logic pump_hiz_reg;
   logic pump_half_reg;
   logic held_ref_reg;
   logic held_fb_reg;
   logic [1:0] power_reg;

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         pump_up_reg   <= 1'b0;
         pump_dn_reg   <= 1'b0;
         pump_hiz_reg  <= 1'b1;
         pump_half_reg <= 1'b0;
      end else if (ctl_w[`PDC_CTRL_MIDSUP] || loop_off) begin
         pump_up_reg   <= 1'b0;
         pump_dn_reg   <= 1'b0;
         pump_hiz_reg  <= 1'b1;
         pump_half_reg <= ctl_w[`PDC_CTRL_MIDSUP];
      end else begin
         pump_half_reg <= 1'b0;
         case (pump_mode)
            PDC_PUMP_HIZ: begin
               pump_up_reg  <= 1'b0;
               pump_dn_reg  <= 1'b0;
               pump_hiz_reg <= 1'b1;
            end
            PDC_PUMP_SOURCE: begin
               pump_up_reg  <= 1'b1;
               pump_dn_reg  <= 1'b0;
               pump_hiz_reg <= 1'b0;
            end
            PDC_PUMP_SINK: begin
               pump_up_reg  <= 1'b0;
               pump_dn_reg  <= 1'b1;
               pump_hiz_reg <= 1'b0;
            end
            default: begin
               pump_up_reg  <= PFD_UP;
               pump_dn_reg  <= PFD_DOWN;
               pump_hiz_reg <= !(PFD_UP || PFD_DOWN);
            end
         endcase
      end
   end

   // Status outputs
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         held_ref_reg <= 1'b1;
         held_fb_reg  <= 1'b1;
         power_reg    <= 2'h1;
      end else begin
         held_ref_reg <= hold_ref;
         held_fb_reg  <= hold_fb;
         power_reg    <= pwr_mode;
      end
   end

   assign REF_DIV_OUT      = ref_out_reg;
   assign FB_DIV_OUT       = fb_out_reg;
   assign MOD_SEL          = mod_sel_reg;
   assign REF_DIV_HELD     = held_ref_reg;
   assign FB_DIV_HELD      = held_fb_reg;
   assign PUMP_OUTPUT_UP   = pump_up_reg;
   assign PUMP_OUTPUT_DOWN = pump_dn_reg;
   assign PUMP_OUTPUT_HIZ  = pump_hiz_reg;
   assign PUMP_SUPPLY_HALF = pump_half_reg;
   assign LOOP_POWER       = power_reg;

endmodule : pdc_top

`default_nettype wire

// ---- tb/pdc_top_chk.sv ----
`default_nettype none

`include "pdc_cfg.svh"

// ----------------------------------------------------------------------
// Port checker for the divider control block
// ----------------------------------------------------------------------
module pdc_top_chk
   import pdc_pkg::*;
(
   // Clock and reset
   input wire logic       CLK_SYS,
   input wire logic       RST,
   // Register port
   input wire logic [9:0] REG_ADDR,
   input wire logic       REG_RD,
   input wire logic [7:0] REG_RDATA,
   // Divider side
   input wire logic       REF_TICK,
   input wire logic       FB_TICK,
   input wire logic       REF_DIV_OUT,
   input wire logic       FB_DIV_OUT,
   input wire logic       MOD_SEL,
   input wire logic       REF_DIV_HELD,
   input wire logic       FB_DIV_HELD,
   // Pump side
   input wire logic       PUMP_OUTPUT_UP,
   input wire logic       PUMP_OUTPUT_DOWN,
   input wire logic       PUMP_OUTPUT_HIZ,
   input wire logic       PUMP_SUPPLY_HALF,
   input wire logic [1:0] LOOP_POWER
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   // Pump and power relations
   a_hiz_quiet: assert property (PUMP_OUTPUT_HIZ |->
      !(PUMP_OUTPUT_UP || PUMP_OUTPUT_DOWN)) else $error("hiz drives");
   a_half_parks: assert property (PUMP_SUPPLY_HALF |->
      PUMP_OUTPUT_HIZ && !PUMP_OUTPUT_UP) else $error("half not parked");
   a_power_holds: assert property
      (LOOP_POWER != 2'h0 && $past(LOOP_POWER) != 2'h0 |->
      REF_DIV_HELD && FB_DIV_HELD && PUMP_OUTPUT_HIZ)
      else $error("power down not holding");
   // Held dividers stay quiet
   a_ref_held_quiet: assert property
      (REF_DIV_HELD && $past(REF_DIV_HELD) |-> !REF_DIV_OUT)
      else $error("ref pulse while held");
   a_fb_held_quiet: assert property
      (FB_DIV_HELD && $past(FB_DIV_HELD) |-> !FB_DIV_OUT && !MOD_SEL)
      else $error("fb activity while held");
   // Pulses need a tick
   a_ref_tick_cause: assert property ($rose(REF_DIV_OUT) |->
      $past(REF_TICK)) else $error("ref pulse without tick");
   a_fb_tick_cause: assert property (FB_DIV_OUT |->
      $past(FB_TICK)) else $error("fb pulse without tick");
   // Readback
   a_rdata_holds: assert property (!$past(REG_RD) |->
      $stable(REG_RDATA)) else $error("read data moved");
   a_unmapped_zero: assert property
      ($past(REG_RD) && $past(REG_ADDR) > `PDC_ADDR_CTRL |->
      REG_RDATA == 8'h00) else $error("unmapped read not zero");
   a_ref_hi_mask: assert property
      ($past(REG_RD) && $past(REG_ADDR) == `PDC_ADDR_REF_HI |->
      REG_RDATA[7:6] == 2'h0) else $error("ref high unused bits");
   a_main_hi_mask: assert property
      ($past(REG_RD) && $past(REG_ADDR) == `PDC_ADDR_MAIN_HI |->
      REG_RDATA[7:5] == 3'h0) else $error("main high unused bits");
endmodule : pdc_top_chk

`default_nettype wire

// ---- tb/pdc_top_tb.sv ----
`default_nettype none

`include "pdc_cfg.svh"

// ----------------------------------------------------------------------
// Register sequence bench
// ----------------------------------------------------------------------
module pdc_top_tb
   import pdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic       CLK_SYS = 1'b0, RST = 1'b1;
   logic [9:0] REG_ADDR = 10'h000;
   logic [7:0] REG_WDATA = 8'h00, REG_RDATA;
   logic       REG_WR = 1'b0, REG_RD = 1'b0, REG_UPDATE = 1'b0;
   logic       REF_TICK = 1'b0, FB_TICK = 1'b0;
   logic       PFD_UP = 1'b0, PFD_DOWN = 1'b0;
   logic       REF_DIV_OUT, FB_DIV_OUT, MOD_SEL, REF_DIV_HELD, FB_DIV_HELD;
   logic       PUMP_OUTPUT_UP, PUMP_OUTPUT_DOWN, PUMP_OUTPUT_HIZ;
   logic       PUMP_SUPPLY_HALF;
   logic [1:0] LOOP_POWER;
   int         fails = 0, n_compared = 0, np, nm, i;
   // Address, reset value and read mask of each divider register
   logic [9:0] ta [7] = '{10'h010, 10'h011, 10'h012, 10'h013, 10'h014,
                          10'h015, 10'h016};
   logic [7:0] tr [7] = '{8'h0D, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
   logic [7:0] tm [7] = '{8'h0F, 8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'h1F, 8'hF8};
   logic [7:0] cv [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
   logic [7:0] ce [4] = '{8'h09, 8'h21, 8'h11, 8'h31};
   logic [7:0] pe [4] = '{8'h01, 8'h04, 8'h02, 8'h04};

   pdc_top dut (.CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_UPDATE(REG_UPDATE), .REG_RDATA(REG_RDATA),
      .REF_TICK(REF_TICK), .FB_TICK(FB_TICK), .PFD_UP(PFD_UP),
      .PFD_DOWN(PFD_DOWN), .REF_DIV_OUT(REF_DIV_OUT),
      .FB_DIV_OUT(FB_DIV_OUT), .MOD_SEL(MOD_SEL),
      .REF_DIV_HELD(REF_DIV_HELD), .FB_DIV_HELD(FB_DIV_HELD),
      .PUMP_OUTPUT_UP(PUMP_OUTPUT_UP), .PUMP_OUTPUT_DOWN(PUMP_OUTPUT_DOWN),
      .PUMP_OUTPUT_HIZ(PUMP_OUTPUT_HIZ),
      .PUMP_SUPPLY_HALF(PUMP_SUPPLY_HALF), .LOOP_POWER(LOOP_POWER));

   // 20 MHz clock
   initial begin
      forever #25 CLK_SYS = ~CLK_SYS;
   end

   task chk(input string nam, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nam, e, g);
      end
   endtask : chk

   task wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge CLK_SYS);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
   endtask : wr

   task rd(input logic [9:0] a, input logic [7:0] e);
      @(posedge CLK_SYS);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      @(posedge CLK_SYS);
      #1 chk("rdata", e, REG_RDATA);
   endtask : rd

   // Apply buffer bank, then compare the packed pump and loop status
   task st(input logic [7:0] e);
      @(posedge CLK_SYS);
      REG_UPDATE <= 1'b1;
      @(posedge CLK_SYS);
      REG_UPDATE <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
      #1 chk("status", e, {LOOP_POWER, REF_DIV_HELD, FB_DIV_HELD,
         PUMP_SUPPLY_HALF, PUMP_OUTPUT_UP, PUMP_OUTPUT_DOWN, PUMP_OUTPUT_HIZ});
   endtask : st

   // Tick one divider n cycles, count pulses and modulus-select ticks
   task ticks(input logic fb, input int n, input int ep, input int em);
      np = 0;
      nm = 0;
      for (int k = 0; k < n + 3; k++) begin
         @(posedge CLK_SYS);
         REF_TICK <= !fb && k < n;
         FB_TICK <= fb && k < n;
         #1 np += fb ? int'(FB_DIV_OUT) : int'(REF_DIV_OUT);
         nm += (fb && k < n) ? int'(MOD_SEL) : 0;
      end
      chk("pulses", 8'(ep), 8'(np));
      chk("modsel", 8'(em), 8'(nm));
   endtask : ticks

   task summarize;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   // Watchdog
   initial begin
      #2000000;
      fails++;
      summarize();
   end

   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge CLK_SYS);
      RST <= 1'b0;
      #1 chk("status", 8'h71, {LOOP_POWER, REF_DIV_HELD, FB_DIV_HELD,
         PUMP_SUPPLY_HALF, PUMP_OUTPUT_UP, PUMP_OUTPUT_DOWN,
         PUMP_OUTPUT_HIZ});
      for (i = 0; i < 7; i++) begin
         rd(ta[i], tr[i]);
         wr(ta[i], 8'hFF);
         rd(ta[i], tm[i]);
         wr(ta[i], tr[i]);
      end
      wr(10'h020, 8'hFF);
      rd(10'h020, 8'h00);
      rd(`PDC_ADDR_READSEL, 8'h00);
      wr(`PDC_ADDR_REF_LO, 8'h05);
      wr(`PDC_ADDR_READSEL, 8'h01);
      rd(`PDC_ADDR_REF_LO, 8'h01);
      st(8'h71);
      rd(`PDC_ADDR_REF_LO, 8'h05);
      wr(`PDC_ADDR_READSEL, 8'h00);
      wr(`PDC_ADDR_PUMP_PWR, 8'h0C);
      wr(`PDC_ADDR_REF_LO, 8'h03);
      st(8'h01);
      ticks(1'b0, 9, 3, 0);
      ticks(1'b1, 9, 3, 0);
      wr(`PDC_ADDR_SWALLOW, 8'h01);
      st(8'h01);
      ticks(1'b1, 9, 3, 3);
      wr(`PDC_ADDR_CTRL, 8'h08);
      st(8'h01);
      ticks(1'b1, 9, 9, 0);
      for (i = 0; i < 4; i++) begin
         wr(`PDC_ADDR_CTRL, cv[i]);
         st(ce[i]);
         ticks(1'b0, 6, cv[i][6] || cv[i][4] ? 0 : 2, 0);
         ticks(1'b1, 6, cv[i][5] || cv[i][4] ? 0 : 2,
            cv[i][5] || cv[i][4] ? 0 : 2);
      end
      wr(`PDC_ADDR_CTRL, 8'h00);
      @(posedge CLK_SYS);
      PFD_UP <= 1'b1;
      for (i = 0; i < 4; i++) begin
         wr(`PDC_ADDR_PUMP_PWR, 8'(i << 2));
         st(pe[i]);
      end
      @(posedge CLK_SYS);
      PFD_UP <= 1'b0;
      PFD_DOWN <= 1'b1;
      st(8'h02);
      for (i = 1; i < 4; i++) begin
         wr(`PDC_ADDR_PUMP_PWR, 8'(8'h0C | i));
         st({2'(i), 6'h31});
         ticks(1'b0, 6, 0, 0);
      end
      @(posedge CLK_SYS);
      RST <= 1'b1;
      @(posedge CLK_SYS);
      RST <= 1'b0;
      rd(`PDC_ADDR_PUMP_PWR, 8'h0D);
      summarize();
   end
endmodule : pdc_top_tb

bind pdc_top pdc_top_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
   .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .REF_TICK(REF_TICK), .FB_TICK(FB_TICK), .REF_DIV_OUT(REF_DIV_OUT),
   .FB_DIV_OUT(FB_DIV_OUT), .MOD_SEL(MOD_SEL),
   .REF_DIV_HELD(REF_DIV_HELD), .FB_DIV_HELD(FB_DIV_HELD),
   .PUMP_OUTPUT_UP(PUMP_OUTPUT_UP), .PUMP_OUTPUT_DOWN(PUMP_OUTPUT_DOWN),
   .PUMP_OUTPUT_HIZ(PUMP_OUTPUT_HIZ), .PUMP_SUPPLY_HALF(PUMP_SUPPLY_HALF),
   .LOOP_POWER(LOOP_POWER));

`default_nettype wire
